// file: core/prescaler_pkg.sv
// Constants, register map and power-mode type for the dual prescaler block.
// Assumes a single 50 MHz bus clock and an AXI4-Lite master with 32-bit data.
package prescaler_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 20;
  localparam int SYS_W              = 13;
  localparam int WATCH_W            = 5;
  localparam int MEDIUM_DIV         = 16;
  localparam int WATCH_PRE_DIV      = 4;
  localparam int SUB_IDLE_NS        = 61040;
  localparam int SUB_IDLE_CYC       = (SUB_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  POWER_MODE_OFF   = 4'h0;
  localparam logic [3:0]  TIMEKEEP_OFF     = 4'h4;
  localparam logic [3:0]  STATUS_OFF       = 4'h8;
  localparam int          MODE_LSB         = 0;
  localparam int          CLEAR_LO_BIT     = 2;
  localparam int          CLEAR_HI_BIT     = 3;
  localparam int          ST_SYS_RUN_BIT   = 0;
  localparam int          ST_SUB_ALIVE_BIT = 1;
  localparam int          ST_WATCH_LSB     = 8;
  localparam logic [3:0]  TIMEKEEP_RESET   = 4'h0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE_HIGH,
    MODE_ACTIVE_MEDIUM,
    MODE_SLEEP,
    MODE_SUBACTIVE,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } power_mode_t;

  localparam power_mode_t MODE_RESET = MODE_ACTIVE_HIGH;

endpackage : prescaler_pkg

// file: core/dual_clock_prescalers.sv
// System and watch prescalers with an AXI4-Lite control port.
// Assumes the subclock pin is already synchronous to aclk and that aclk is
// the oscillator clock, so one aclk cycle is one system clock period.
// How it works
// - Provide a system clock tick and a subclock-derived watch clock.
// - System prescaler is a 13-bit up-counter, plus one per system clock.
// - Reset clears the system prescaler; counting starts right after release.
// - Standby, watch, subactive and subsleep stop and zero the system prescaler.
// - Software can neither read nor write the system prescaler.
// - System taps offer every power-of-two division from 2 to 8192.
// - One shared tap bus; each peripheral picks its own ratio.
// - In medium-speed mode the system prescaler input is oscillator over 16.
// - Watch prescaler is a 5-bit up-counter fed by watch clock over four.
// - Reset clears the watch prescaler; counting starts on reset exit.
// - Watch prescaler keeps counting in all low-power modes with subclock.
// - Writing both clear bits of the timekeeping mode register zeroes it.
// - Watch taps run from undivided watch clock down to division by 128.
`timescale 1ns/10ps

module dual_clock_prescalers #(
  parameter int SYS_W   = prescaler_pkg::SYS_W,
  parameter int WATCH_W = prescaler_pkg::WATCH_W
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [3:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [3:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic                 subclock_input_pin,
  output logic                      sys_clock_tick,
  output logic [SYS_W-1:0]          sys_taps,
  output logic [WATCH_W+2:0]        watch_taps
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic                       aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [3:0]                 awaddr_q, awaddr_d;
  logic [31:0]                wdata_q, wdata_d;
  logic [3:0]                 wstrb_q, wstrb_d;
  logic                       awready_q, awready_d, wready_q, wready_d;
  logic                       bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
  logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       wr_fire, watch_clr;
  logic [3:0]                 wr_addr;
  logic [31:0]                wr_data;
  logic [3:0]                 wr_strb;
  prescaler_pkg::power_mode_t mode_q, mode_d;
  logic [3:0]                 timekeep_q, timekeep_d;

  // Core state declared here so the read mux can see it.
  logic [SYS_W-1:0]           system_prescaler_q, system_prescaler_d;
  logic [WATCH_W-1:0]         watch_prescaler_q, watch_prescaler_d;
  logic                       sub_alive_q;
  logic                       sys_stop;

  always_comb begin
    wr_addr    = aw_hold_q ? awaddr_q : awaddr;
    wr_data    = w_hold_q ? wdata_q : wdata;
    wr_strb    = w_hold_q ? wstrb_q : wstrb;
    aw_hold_d  = aw_hold_q | (awvalid & awready_q);
    w_hold_d   = w_hold_q | (wvalid & wready_q);
    awaddr_d   = (awvalid & awready_q) ? awaddr : awaddr_q;
    wdata_d    = (wvalid & wready_q) ? wdata : wdata_q;
    wstrb_d    = (wvalid & wready_q) ? wstrb : wstrb_q;
    wr_fire    = aw_hold_d & w_hold_d & ~bvalid_q;
    bvalid_d   = wr_fire | (bvalid_q & ~bready);
    bresp_d    = bresp_q;
    mode_d     = mode_q;
    timekeep_d = timekeep_q;
    watch_clr  = 1'b0;
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bresp_d   = prescaler_pkg::RESP_OKAY;
      // The system prescaler has no address, so no write can reach it.
      case (wr_addr)
        prescaler_pkg::POWER_MODE_OFF: begin
          // Codes past the last mode are dropped so the mode stays legal.
          if (wr_strb[0] && wr_data[2:0] <= 3'(prescaler_pkg::MODE_STANDBY)) begin
            mode_d = prescaler_pkg::power_mode_t'(wr_data[prescaler_pkg::MODE_LSB +: 3]);
          end
        end
        prescaler_pkg::TIMEKEEP_OFF: begin
          if (wr_strb[0]) begin
            timekeep_d = wr_data[3:0];
            watch_clr  = wr_data[prescaler_pkg::CLEAR_HI_BIT] &
                         wr_data[prescaler_pkg::CLEAR_LO_BIT];
          end
        end
        prescaler_pkg::STATUS_OFF: begin
        end
        default: begin
          bresp_d = prescaler_pkg::RESP_DECERR;
        end
      endcase
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d  = ~w_hold_d & ~bvalid_d;
    rvalid_d  = rvalid_q & ~rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      rresp_d  = prescaler_pkg::RESP_OKAY;
      case (araddr)
        prescaler_pkg::POWER_MODE_OFF: rdata_d[2:0] = mode_q;
        prescaler_pkg::TIMEKEEP_OFF:   rdata_d[3:0] = timekeep_q;
        prescaler_pkg::STATUS_OFF: begin
          rdata_d[prescaler_pkg::ST_SYS_RUN_BIT]   = ~sys_stop;
          rdata_d[prescaler_pkg::ST_SUB_ALIVE_BIT] = sub_alive_q;
          rdata_d[prescaler_pkg::ST_WATCH_LSB +: WATCH_W] = watch_prescaler_q;
        end
        default: rresp_d = prescaler_pkg::RESP_DECERR;
      endcase
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q  <= 1'b0;
      w_hold_q   <= 1'b0;
      awaddr_q   <= 4'h0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'h0;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= 2'h0;
      mode_q     <= prescaler_pkg::MODE_RESET;
      timekeep_q <= prescaler_pkg::TIMEKEEP_RESET;
    end else begin
      aw_hold_q  <= aw_hold_d;
      w_hold_q   <= w_hold_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      mode_q     <= mode_d;
      timekeep_q <= timekeep_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // ----------------------------------------------------------------
  // System prescaler
  // ----------------------------------------------------------------
  logic [3:0] med_div_q, med_div_d;
  logic       sys_tick, sys_tick_q, is_medium;

  always_comb begin
    sys_stop  = (mode_q == prescaler_pkg::MODE_STANDBY)   ||
                (mode_q == prescaler_pkg::MODE_WATCH)     ||
                (mode_q == prescaler_pkg::MODE_SUBACTIVE) ||
                (mode_q == prescaler_pkg::MODE_SUBSLEEP);
    is_medium = (mode_q == prescaler_pkg::MODE_ACTIVE_MEDIUM);
    // The divider is held at zero outside medium speed so that the first
    // medium tick always comes a full sixteen cycles after the switch.
    med_div_d = is_medium ? 4'(med_div_q + 4'h1) : 4'h0;
    sys_tick  = ~sys_stop &
                (~is_medium | (med_div_q == 4'(prescaler_pkg::MEDIUM_DIV - 1)));
    if (sys_stop) begin
      system_prescaler_d = '0;
    end else if (sys_tick) begin
      system_prescaler_d = SYS_W'(system_prescaler_q + 1'b1);
    end else begin
      system_prescaler_d = system_prescaler_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_prescaler_q <= '0;
      med_div_q          <= 4'h0;
      sys_tick_q         <= 1'b0;
    end else begin
      system_prescaler_q <= system_prescaler_d;
      med_div_q          <= med_div_d;
      sys_tick_q         <= sys_tick;
    end
  end

  // Bit i is the system clock over 2 to the power i+1, shared by every user.
  assign sys_taps       = system_prescaler_q;
  assign sys_clock_tick = sys_tick_q;

  // ----------------------------------------------------------------
  // Watch prescaler
  // ----------------------------------------------------------------
  logic                       sub_q, sub_prev_q, sub_rise;
  logic [1:0]                 pre_q, pre_d;
  localparam int IDLE_W = $clog2(prescaler_pkg::SUB_IDLE_CYC + 1);
  logic [IDLE_W-1:0]          idle_q, idle_d;
  logic                       sub_alive_d;

  always_comb begin
    sub_rise = sub_q & ~sub_prev_q;
    pre_d    = sub_rise ? 2'(pre_q + 2'h1) : pre_q;
    // No mode term here: the watch side runs whenever the subclock toggles.
    if (watch_clr) begin
      watch_prescaler_d = '0;
    end else if (sub_rise && pre_q == 2'(prescaler_pkg::WATCH_PRE_DIV - 1)) begin
      watch_prescaler_d = WATCH_W'(watch_prescaler_q + 1'b1);
    end else begin
      watch_prescaler_d = watch_prescaler_q;
    end
    if (sub_q != sub_prev_q) begin
      idle_d = '0;
    end else if (idle_q != IDLE_W'(prescaler_pkg::SUB_IDLE_CYC)) begin
      idle_d = IDLE_W'(idle_q + 1'b1);
    end else begin
      idle_d = idle_q;
    end
    sub_alive_d = (idle_d != IDLE_W'(prescaler_pkg::SUB_IDLE_CYC));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Both samples start at the pin's idle high level, so release brings no false edge.
      sub_q             <= 1'b1;
      sub_prev_q        <= 1'b1;
      pre_q             <= 2'h0;
      watch_prescaler_q <= '0;
      idle_q            <= '0;
      sub_alive_q       <= 1'b0;
    end else begin
      sub_q             <= subclock_input_pin;
      sub_prev_q        <= sub_q;
      pre_q             <= pre_d;
      watch_prescaler_q <= watch_prescaler_d;
      idle_q            <= idle_d;
      sub_alive_q       <= sub_alive_d;
    end
  end

  // Undivided, over 2, over 4, then the counter bits for over 8 to over 128.
  assign watch_taps = {watch_prescaler_q, pre_q[1], pre_q[0], sub_q};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_medium_tick;
    is_medium && sys_tick;
  endsequence

  sequence s_watch_step;
    sub_rise && pre_q == 2'h3 && !watch_clr;
  endsequence

  property p_sys_step;
    @(posedge aclk) disable iff (!aresetn)
      sys_tick |=> system_prescaler_q == SYS_W'($past(system_prescaler_q) + 1'b1);
  endproperty
  a_sys_step: assert property (p_sys_step) else $error("system count did not step");

  property p_sys_reset;
    @(posedge aclk) !aresetn |=> system_prescaler_q == '0 && sys_clock_tick == 1'b0;
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("system count not cleared");

  property p_sys_stop;
    @(posedge aclk) disable iff (!aresetn)
      sys_stop |=> system_prescaler_q == '0 && !sys_clock_tick;
  endproperty
  a_sys_stop: assert property (p_sys_stop) else $error("system count ran when stopped");

  property p_sys_hidden;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && !sys_stop |=> system_prescaler_q ==
        SYS_W'($past(system_prescaler_q) + SYS_W'($past(sys_tick)));
  endproperty
  a_sys_hidden: assert property (p_sys_hidden) else $error("write disturbed count");

  property p_medium_rate;
    @(posedge aclk) disable iff (!aresetn)
      s_medium_tick |=> (!sys_tick || !is_medium) [*8] ##1 (!sys_tick || !is_medium) [*7]
        ##1 (sys_tick || !is_medium);
  endproperty
  a_medium_rate: assert property (p_medium_rate) else $error("medium rate not 16");

  property p_watch_step;
    @(posedge aclk) disable iff (!aresetn)
      s_watch_step |=> watch_prescaler_q == WATCH_W'($past(watch_prescaler_q) + 1'b1);
  endproperty
  a_watch_step: assert property (p_watch_step) else $error("watch count did not step");

  property p_watch_reset;
    @(posedge aclk) !aresetn |=> watch_prescaler_q == '0 && pre_q == 2'h0;
  endproperty
  a_watch_reset: assert property (p_watch_reset) else $error("watch count not cleared");

  property p_watch_in_stop;
    @(posedge aclk) disable iff (!aresetn)
      sys_stop ##0 s_watch_step |=> watch_prescaler_q != $past(watch_prescaler_q);
  endproperty
  a_watch_in_stop: assert property (p_watch_in_stop) else $error("watch halted in stop");

  property p_watch_clear;
    @(posedge aclk) disable iff (!aresetn)
      watch_clr |=> watch_prescaler_q == '0;
  endproperty
  a_watch_clear: assert property (p_watch_clear) else $error("watch clear ignored");

  property p_sys_wrap;
    @(posedge aclk) disable iff (!aresetn)
      system_prescaler_q == '1 && sys_tick |=> system_prescaler_q == '0;
  endproperty
  a_sys_wrap: assert property (p_sys_wrap) else $error("system count did not wrap");

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
      bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

endmodule : dual_clock_prescalers

// file: verification/subclock_source.sv
// Stand-in for the external square-wave source on the subclock pin.
// Assumes it is clocked from aclk, so its edges land just after aclk rises.
`timescale 1ns/10ps

module subclock_source #(
  parameter int HALF = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      subclock
);
  int cnt_q;

  // Stopped, the pin rests high, as an unused subclock pin is tied.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q    <= 0;
      subclock <= 1'b1;
    end else if (cnt_q == HALF - 1) begin
      cnt_q    <= 0;
      subclock <= ~subclock;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : subclock_source

// file: verification/tb_dual_clock_prescalers.sv
// Self-checking bench for the dual prescalers: AXI4-Lite master tasks and checks.
// Assumes the subclock model runs much faster than a real crystal to keep runs short.
`timescale 1ns/10ps

module tb_dual_clock_prescalers;
  localparam int SUB_HALF = 16;
  localparam int WIN      = 4 * 2 * SUB_HALF * 5;
  logic                                aclk, aresetn, awvalid, wvalid, bready;
  logic                                arvalid, rready, sub_run, subclock;
  logic [3:0]                          awaddr, wstrb, araddr;
  logic [31:0]                         wdata, rdata, rd, seed;
  logic                                awready, wready, bvalid, arready, rvalid, sys_clock_tick;
  logic [1:0]                          bresp, rresp, rsp;
  logic [prescaler_pkg::SYS_W-1:0]     sys_taps, s0, d13;
  logic [prescaler_pkg::WATCH_W+2:0]   watch_taps;
  logic [prescaler_pkg::WATCH_W-1:0]   wcnt, w0;
  logic [2:0]                          cur_mode, m;
  int                                  fail_count, checked;

  assign wcnt = watch_taps[prescaler_pkg::WATCH_W+2:3];

  dual_clock_prescalers DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .subclock_input_pin(subclock), .sys_clock_tick(sys_clock_tick),
    .sys_taps(sys_taps), .watch_taps(watch_taps));

  subclock_source #(.HALF(SUB_HALF)) sub_src (.aclk(aclk), .aresetn(aresetn),
    .run(sub_run), .subclock(subclock));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Ticks seen in a 32-cycle window once a mode has settled.
  function automatic logic [31:0] exp_ticks(input logic [2:0] md);
    if (md == 3'h1) return 32'h0000_0002;
    if (md >= 3'h3) return 32'h0000_0000;
    return 32'h0000_0020;
  endfunction : exp_ticks

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_resp

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // One edge with the response waiting and bready low exercises the hold.
    @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic check_mode(input logic [2:0] md);
    int ticks, t0, t1, t2;
    logic [prescaler_pkg::WATCH_W+2:0] wt;
    ticks = 0;
    repeat (20) @(negedge aclk);
    s0 = sys_taps;
    repeat (32) begin
      @(negedge aclk);
      if (sys_clock_tick === 1'b1) ticks++;
    end
    d13 = sys_taps - s0;
    cmp_val("tick count", exp_ticks(md), ticks);
    cmp_val("system step", exp_ticks(md), 32'(d13));
    if (md >= 3'h3) cmp_val("stopped count", 32'h0, 32'(sys_taps));
    w0 = wcnt;
    wt = watch_taps;
    t0 = 0;
    t1 = 0;
    t2 = 0;
    repeat (WIN) begin
      @(negedge aclk);
      if (watch_taps[0] === 1'b1 && wt[0] === 1'b0) t0++;
      if (watch_taps[1] === 1'b1 && wt[1] === 1'b0) t1++;
      if (watch_taps[2] === 1'b1 && wt[2] === 1'b0) t2++;
      wt = watch_taps;
    end
    cmp_val("watch tap rises", 32'h0000_0014, 32'(t0));
    cmp_val("watch over 2 rises", 32'h0000_000A, 32'(t1));
    cmp_val("watch over 4 rises", 32'h0000_0005, 32'(t2));
    cmp_val("watch step", 32'h5, 32'(5'(wcnt - w0)));
    axi_read(prescaler_pkg::STATUS_OFF, rd, rsp);
    cmp_val("running flag", 32'(md < 3'h3), 32'(rd[0]));
  endtask : check_mode

  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    checked = 0;
    seed = 32'h1B306BC3;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wstrb, araddr, wdata} = 44'h0;
    sub_run = 1'b1;
    cur_mode = 3'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_val("reset count", 32'h0, 32'(sys_taps));
    // The undivided tap follows the pin, which the source holds high in reset.
    cmp_val("reset watch", 32'h0000_0001, 32'(watch_taps));
    // Long enough to pass the all-ones wrap of the system count.
    for (int i = 0; i < 8300; i++) begin
      s0 = sys_taps;
      @(negedge aclk);
      d13 = sys_taps - s0;
      cmp_val("system step", 32'h1, 32'(d13));
    end
    axi_read(prescaler_pkg::POWER_MODE_OFF, rd, rsp);
    cmp_val("mode reset", 32'h0, rd);
    axi_read(prescaler_pkg::TIMEKEEP_OFF, rd, rsp);
    cmp_val("timekeep reset", 32'h0, rd);
    // Every mode once in table order, then random codes including the ignored one.
    for (int i = 0; i < 17; i++) begin
      m = (i < 7) ? 3'(i) : 3'(rnd() % 8);
      axi_write(prescaler_pkg::POWER_MODE_OFF, 32'(m), rsp);
      cmp_resp("mode resp", prescaler_pkg::RESP_OKAY, rsp);
      if (m != 3'h7) cur_mode = m;
      axi_read(prescaler_pkg::POWER_MODE_OFF, rd, rsp);
      cmp_val("mode readback", 32'(cur_mode), rd);
      check_mode(cur_mode);
    end
    while (wcnt !== 5'h4) @(negedge aclk);
    axi_write(prescaler_pkg::TIMEKEEP_OFF, 32'h4, rsp);
    @(negedge aclk);
    cmp_val("one clear bit", 32'h1, 32'(wcnt >= 5'h3));
    axi_write(prescaler_pkg::TIMEKEEP_OFF, 32'hC, rsp);
    @(negedge aclk);
    cmp_val("watch cleared", 32'h1, 32'(wcnt < 5'h2));
    axi_read(prescaler_pkg::TIMEKEEP_OFF, rd, rsp);
    cmp_val("timekeep readback", 32'hC, rd);
    sub_run <= 1'b0;
    repeat (3200) @(negedge aclk);
    w0 = wcnt;
    axi_read(prescaler_pkg::STATUS_OFF, rd, rsp);
    cmp_val("subclock lost", 32'h0, 32'(rd[1]));
    repeat (200) @(negedge aclk);
    cmp_val("watch held", 32'(w0), 32'(wcnt));
    sub_run <= 1'b1;
    repeat (300) @(negedge aclk);
    axi_read(prescaler_pkg::STATUS_OFF, rd, rsp);
    cmp_val("subclock alive", 32'h1, 32'(rd[1]));
    axi_write(4'hC, 32'hFFFF_FFFF, rsp);
    cmp_resp("unmapped write", prescaler_pkg::RESP_DECERR, rsp);
    axi_read(4'hC, rd, rsp);
    cmp_resp("unmapped read", prescaler_pkg::RESP_DECERR, rsp);
    results();
  end
endmodule : tb_dual_clock_prescalers
